// file: rtl/fcr_crc16.sv
// Purpose: byte serial crc16 over program memory
// Assumes: one byte per valid strobe, msb first
// Notes:   start reloads the seed before the first byte
`timescale 1ns/100ps
module fcr_crc16 (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // byte stream
    input  wire logic        start,
    input  wire logic        byte_valid,
    input  wire logic [7:0]  byte_data,
    // running value
    output logic      [15:0] crc_q
);
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ({r[14:0], 1'b0} ^ fcr_pkg::CRC_POLY) : {r[14:0], 1'b0};
        end
        return r;
    endfunction

    wire [15:0] crc_next = crc_byte(crc_q, byte_data);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            crc_q <= fcr_pkg::CRC_INIT;
        end else if (start) begin
            crc_q <= fcr_pkg::CRC_INIT;
        end else if (byte_valid) begin
            crc_q <= crc_next;
        end
    end
endmodule // fcr_crc16

// file: rtl/fcr_filter.sv
// Purpose: persistence filter, flags a level held longer than a time
// Assumes: input from logic on the same clock
// Notes:   trips once count reaches the limit; drops with the input
`timescale 1ns/100ps
module fcr_filter #(
    parameter int unsigned LIMIT = 10000000,
    parameter int unsigned WIDTH = 24
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // level in, filtered level out
    input  wire logic level_in,
    output logic      tripped
);
    logic [WIDTH-1:0] count_q;
    wire              at_limit = (count_q >= WIDTH'(LIMIT));

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count_q <= '0;
            tripped <= 1'b0;
        end else if (!level_in) begin
            count_q <= '0;
            tripped <= 1'b0;
        end else if (at_limit) begin
            tripped <= 1'b1;
        end else begin
            count_q <= count_q + 1'b1;
        end
    end
endmodule // fcr_filter

// file: rtl/fcr_pkg.sv
// Purpose: shared constants of the fault code reporter
// Assumes: 20 MHz module clock
// Notes:   fault bit n stands for fault index n+9
package fcr_pkg;

    localparam int unsigned NUM_FAULTS = 19;
    localparam int unsigned FIRST_INDEX = 9;

    // fault bit positions
    localparam int unsigned FB_HANDSHAKE = 0;
    localparam int unsigned FB_WD_POST   = 1;
    localparam int unsigned FB_OS_FAIL   = 2;
    localparam int unsigned FB_POS_TEST  = 3;
    localparam int unsigned FB_NB_POS    = 4;
    localparam int unsigned FB_TEMP_SENS = 5;
    localparam int unsigned FB_RAM       = 6;
    localparam int unsigned FB_TEMP_AVG  = 7;
    localparam int unsigned FB_PROG_CRC  = 8;
    localparam int unsigned FB_NV_WRITE  = 10;
    localparam int unsigned FB_NV_CRC    = 11;
    localparam int unsigned FB_NV_MIRROR = 12;
    localparam int unsigned FB_DEADBAND  = 13;
    localparam int unsigned FB_CAN_PASS  = 15;
    localparam int unsigned FB_CAN_RECOV = 17;
    localparam int unsigned FB_PDO_LEN   = 18;

    // emergency codes and error register values, bit 0 first
    localparam logic [15:0] ERR_CODE [0:18] = '{
        16'h6205, 16'h6206, 16'h6207, 16'h5231, 16'h5232, 16'h5233, 16'h5511,
        16'h4223, 16'h5521, 16'h5001, 16'h5532, 16'h5533, 16'h5534, 16'h6321,
        16'h8110, 16'h8120, 16'h8130, 16'h8140, 16'h8210};
    localparam logic [7:0] ERR_REG [0:18] = '{
        8'h81, 8'h81, 8'h81, 8'h21, 8'h21, 8'h21, 8'h81, 8'h09, 8'h81, 8'h81,
        8'h81, 8'h81, 8'h81, 8'h81, 8'h11, 8'h11, 8'h11, 8'h11, 8'h11};

    localparam logic [15:0] OD_INDEX_BASE = 16'h2008;

    // clearing classes; faults in none of the masks clear only at power-up
    localparam logic [18:0] APP_CLR_MASK  = 19'h034b8;
    localparam logic [18:0] COMM_CLR_MASK = 19'h08000;
    localparam logic [18:0] RESERVED_MASK = 19'h14200;
    localparam logic [18:0] FAULTS_RESET  = 19'h00000;

    // limits
    localparam logic signed [15:0] DB_POS_MAX   = 16'sh03e8;
    localparam logic signed [15:0] DB_NEG_MIN   = -16'sh03e8;
    localparam logic signed [15:0] TEMP_AVG_MAX = 16'sh0055;
    localparam logic [7:0]         CAN_TEC_WARN = 8'h7f;

    // position filter time
    localparam int unsigned POS_FILT_MS    = 500;
    localparam int unsigned CLK_KHZ        = 20000;
    localparam int unsigned POS_FILT_CYC   = POS_FILT_MS * CLK_KHZ;

    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'h1021;

    typedef enum logic [0:0] {
        REP_IDLE = 1'b0,
        REP_SEND = 1'b1
    } fcr_rep_state_t;

endpackage

// file: rtl/fcr_reporter.sv
// Purpose: fault supervision latches and emergency report sequencer
// Assumes: all check inputs come from logic on clk; reset is the power cycle
// Notes:   one emergency record is offered at a time, lowest index first
//
// Functional notes
// - missed supervisor handshake raises 6205, power clear
// - bad supervisor start-up raises 6206, power clear
// - os task or buffer failure raises 6207
// - position test invalid over 500ms raises 5231
// - neighbour position out of range raises 5232
// - temperature sensor out of range raises 5233
// - start-up ram stuck cell raises 5511
// - average board temperature above 85 raises 4223
// - program memory crc16 mismatch raises 5521
// - unconfirmed nonvolatile write raises 5532
// - start-up nonvolatile crc mismatch raises 5533
// - repair bad nonvolatile copy, raise 5534
// - dead-band out of range raises 6321, blocks
// - error passive above count 127 raises 8120
// - heartbeat-loss code 8130 never raised
// - recovery from passive or bus-off reports 8140
// - wrong length pdo ignored, raises 8210
// - dictionary index 2008 upward per fault
// - reserved entries keep slots, never raised
`timescale 1ns/100ps
module fcr_reporter #(
    parameter int unsigned POS_FILT_CYCLES = fcr_pkg::POS_FILT_CYC,
    parameter int unsigned NB_POS_MIN      = 12'h0cc,
    parameter int unsigned NB_POS_MAX      = 12'hf33
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               reset,
    // clearing events
    input  wire logic               app_reset,
    input  wire logic               comm_reset,
    // supervisor and os checks
    input  wire logic               sup_handshake_miss,
    input  wire logic               sup_post_bad,
    input  wire logic               os_fail,
    input  wire logic               ram_test_fail,
    // sensors
    input  wire logic               pos_test_invalid,
    input  wire logic               nb_pos_valid,
    input  wire logic        [11:0] nb_pos_value,
    input  wire logic               temp_sensor_bad,
    input  wire logic               temp_avg_valid,
    input  wire logic signed [15:0] temp_avg,
    // program memory crc
    input  wire logic               prog_crc_start,
    input  wire logic               prog_byte_valid,
    input  wire logic        [7:0]  prog_byte,
    input  wire logic               prog_byte_last,
    input  wire logic        [15:0] prog_crc_stored,
    // nonvolatile memory
    input  wire logic               nv_write_done,
    input  wire logic               nv_readback_ok,
    input  wire logic               nv_boot_check,
    input  wire logic        [15:0] nv_crc_calc,
    input  wire logic        [15:0] nv_crc_expected,
    input  wire logic               nv_main_crc_ok,
    input  wire logic               nv_mirror_crc_ok,
    input  wire logic               nv_copies_differ,
    input  wire logic               boot_done,
    // dead-band parameters
    input  wire logic               db_load,
    input  wire logic signed [15:0] db_positive,
    input  wire logic signed [15:0] db_negative,
    // can controller state
    input  wire logic        [7:0]  can_tx_err_count,
    input  wire logic               can_err_passive,
    input  wire logic               can_bus_off,
    // received pdo
    input  wire logic               pdo_rx_valid,
    input  wire logic        [3:0]  pdo_rx_len,
    input  wire logic        [3:0]  pdo_expected_len,
    output logic                    pdo_accept,
    // nonvolatile repair request
    output logic                    nv_repair_valid,
    output logic                    nv_repair_from_mirror,
    // fault state
    output logic             [18:0] fault_active,
    output logic             [7:0]  error_register,
    output logic                    operation_blocked,
    // emergency record
    output logic                    emcy_valid,
    input  wire logic               emcy_ready,
    output logic             [15:0] emcy_code,
    output logic             [7:0]  emcy_err_reg,
    output logic             [15:0] emcy_od_index
);
    // helpers
    function automatic logic [4:0] first_set(input logic [18:0] v);
        logic [4:0] r;
        r = 5'd0;
        for (int i = 18; i >= 0; i--) begin
            if (v[i]) r = 5'(i);
        end
        return r;
    endfunction

    function automatic logic [7:0] or_err_reg(input logic [18:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 19; i++) begin
            if (v[i]) r = r | fcr_pkg::ERR_REG[i];
        end
        return r;
    endfunction

    // state
    logic [18:0]                 reported_q;
    logic                        boot_window_q;
    logic                        can_warn_q;
    logic                        can_down_q;
    logic                        crc_check_q;
    fcr_pkg::fcr_rep_state_t     rep_state_q;
    logic [4:0]                  rep_bit_q;

    // position test persistence
    logic pos_tripped;
    fcr_filter #(
        .LIMIT (POS_FILT_CYCLES),
        .WIDTH (24)
    ) u_pos_filter (
        .clk      (clk),
        .reset    (reset),
        .level_in (pos_test_invalid),
        .tripped  (pos_tripped)
    );

    // program memory crc
    logic [15:0] prog_crc;
    fcr_crc16 u_prog_crc (
        .clk        (clk),
        .reset      (reset),
        .start      (prog_crc_start),
        .byte_valid (prog_byte_valid),
        .byte_data  (prog_byte),
        .crc_q      (prog_crc)
    );

    // individual detections
    wire nb_out     = nb_pos_valid &&
                      ((nb_pos_value < 12'(NB_POS_MIN)) || (nb_pos_value > 12'(NB_POS_MAX)));
    wire temp_hot   = temp_avg_valid && (temp_avg > fcr_pkg::TEMP_AVG_MAX);
    wire crc_bad    = crc_check_q && (prog_crc != prog_crc_stored);
    wire nv_wr_bad  = nv_write_done && !nv_readback_ok;
    // only a check during boot counts; later strobes are ignored
    wire nv_boot    = nv_boot_check && boot_window_q;
    wire nv_crc_bad = nv_boot && (nv_crc_calc != nv_crc_expected);
    wire nv_fix     = nv_boot && nv_copies_differ && (nv_main_crc_ok ^ nv_mirror_crc_ok);
    wire db_bad     = db_load &&
                      ((db_positive < 16'sh0000) || (db_positive > fcr_pkg::DB_POS_MAX) ||
                       (db_negative < fcr_pkg::DB_NEG_MIN) || (db_negative > 16'sh0000));
    wire can_warn   = can_err_passive && (can_tx_err_count > fcr_pkg::CAN_TEC_WARN);
    wire can_down   = can_err_passive || can_bus_off;
    wire pdo_bad    = pdo_rx_valid && (pdo_rx_len != pdo_expected_len);

    // raise vector
    logic [18:0] raise_raw;
    always_comb begin
        raise_raw = '0;
        raise_raw[fcr_pkg::FB_HANDSHAKE] = sup_handshake_miss;
        raise_raw[fcr_pkg::FB_WD_POST]   = sup_post_bad;
        raise_raw[fcr_pkg::FB_OS_FAIL]   = os_fail;
        raise_raw[fcr_pkg::FB_POS_TEST]  = pos_tripped;
        raise_raw[fcr_pkg::FB_NB_POS]    = nb_out;
        raise_raw[fcr_pkg::FB_TEMP_SENS] = temp_sensor_bad;
        raise_raw[fcr_pkg::FB_RAM]       = ram_test_fail;
        raise_raw[fcr_pkg::FB_TEMP_AVG]  = temp_hot;
        raise_raw[fcr_pkg::FB_PROG_CRC]  = crc_bad;
        raise_raw[fcr_pkg::FB_NV_WRITE]  = nv_wr_bad;
        raise_raw[fcr_pkg::FB_NV_CRC]    = nv_crc_bad;
        raise_raw[fcr_pkg::FB_NV_MIRROR] = nv_fix;
        raise_raw[fcr_pkg::FB_DEADBAND]  = db_bad;
        raise_raw[fcr_pkg::FB_CAN_PASS]  = can_warn && !can_warn_q;
        raise_raw[fcr_pkg::FB_CAN_RECOV] = can_down_q && !can_down;
        raise_raw[fcr_pkg::FB_PDO_LEN]   = pdo_bad;
    end

    // heartbeat slot and reserved slots are masked off for good
    wire [18:0] raise_vec = raise_raw & ~fcr_pkg::RESERVED_MASK;

    // clearing; an application reset also restarts communication
    wire [18:0] clr_vec = ({19{app_reset}} & fcr_pkg::APP_CLR_MASK) |
                          ({19{app_reset | comm_reset}} & fcr_pkg::COMM_CLR_MASK);

    // set wins over clear in the same cycle
    wire [18:0] active_d = (fault_active & ~clr_vec) | raise_vec;

    // report sequencing
    wire [18:0] pending   = active_d & ~reported_q;
    wire        send_done = (rep_state_q == fcr_pkg::REP_SEND) && emcy_ready;
    wire [18:0] grant_vec = send_done ? (19'h00001 << rep_bit_q) : 19'h00000;
    wire [4:0]  next_bit  = first_set(pending);

    assign emcy_valid = (rep_state_q == fcr_pkg::REP_SEND);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fault_active <= fcr_pkg::FAULTS_RESET;
            reported_q   <= fcr_pkg::FAULTS_RESET;
        end else begin
            fault_active <= active_d;
            // a cleared fault may report again when raised anew
            reported_q   <= (reported_q | grant_vec) & active_d;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            error_register    <= 8'h00;
            operation_blocked <= 1'b0;
        end else begin
            error_register    <= or_err_reg(active_d);
            operation_blocked <= active_d[fcr_pkg::FB_DEADBAND];
        end
    end

    // edge memories and boot window
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            can_warn_q    <= 1'b0;
            can_down_q    <= 1'b0;
            crc_check_q   <= 1'b0;
            boot_window_q <= 1'b1;
        end else begin
            can_warn_q    <= can_warn;
            can_down_q    <= can_down;
            crc_check_q   <= prog_byte_valid && prog_byte_last;
            if (boot_done || nv_boot_check) begin
                boot_window_q <= 1'b0;
            end
        end
    end

    // pdo acceptance and nonvolatile repair requests
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pdo_accept            <= 1'b0;
            nv_repair_valid       <= 1'b0;
            nv_repair_from_mirror <= 1'b0;
        end else begin
            pdo_accept      <= pdo_rx_valid && !pdo_bad;
            nv_repair_valid <= nv_fix;
            if (nv_fix) begin
                nv_repair_from_mirror <= nv_mirror_crc_ok;
            end
        end
    end

    // emergency record holds steady while offered
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rep_state_q   <= fcr_pkg::REP_IDLE;
            rep_bit_q     <= 5'd0;
            emcy_code     <= 16'h0000;
            emcy_err_reg  <= 8'h00;
            emcy_od_index <= 16'h0000;
        end else begin
            case (rep_state_q)
                fcr_pkg::REP_IDLE: begin
                    if (|pending) begin
                        rep_state_q   <= fcr_pkg::REP_SEND;
                        rep_bit_q     <= next_bit;
                        emcy_code     <= fcr_pkg::ERR_CODE[next_bit];
                        emcy_err_reg  <= fcr_pkg::ERR_REG[next_bit];
                        emcy_od_index <= fcr_pkg::OD_INDEX_BASE + {11'h000, next_bit};
                    end
                end
                fcr_pkg::REP_SEND: begin
                    if (emcy_ready) begin
                        rep_state_q <= fcr_pkg::REP_IDLE;
                    end
                end
                default: begin
                    rep_state_q <= fcr_pkg::REP_IDLE;
                end
            endcase
        end
    end

endmodule // fcr_reporter

// file: verification/fault_code_reporter_tb_top.sv
// Purpose: self checking bench of the fault reporter
// Assumes: short position filter of 20 cycles
// Notes:   expected records queue up as fault bit positions
`timescale 1ns/100ps
module fault_code_reporter_tb_top;
    logic        clk, reset, app_reset, comm_reset, sup_handshake_miss, sup_post_bad, os_fail, ram_test_fail;
    logic        pos_test_invalid, nb_pos_valid, temp_sensor_bad, temp_avg_valid, prog_crc_start, prog_byte_valid;
    logic        prog_byte_last, nv_write_done, nv_readback_ok, nv_boot_check, nv_main_crc_ok, nv_mirror_crc_ok;
    logic        nv_copies_differ, boot_done, db_load, can_err_passive, can_bus_off, pdo_rx_valid, pdo_accept;
    logic        nv_repair_valid, nv_repair_from_mirror, operation_blocked, emcy_valid, emcy_ready, slow;
    logic [11:0] nb_pos_value;
    logic [7:0]  prog_byte, can_tx_err_count, error_register, emcy_err_reg;
    logic [15:0] prog_crc_stored, nv_crc_calc, nv_crc_expected, emcy_code, emcy_od_index, crc_r;
    logic signed [15:0] temp_avg, db_positive, db_negative;
    logic [3:0]  pdo_rx_len, pdo_expected_len;
    logic [18:0] fault_active, exp_mask;
    int          code_q[$];
    int          err_total, checks_done, cycles, b;
    integer      seed;

    fcr_reporter #(.POS_FILT_CYCLES(20)) uut (
        .clk, .reset, .app_reset, .comm_reset, .sup_handshake_miss, .sup_post_bad, .os_fail, .ram_test_fail,
        .pos_test_invalid, .nb_pos_valid, .nb_pos_value, .temp_sensor_bad, .temp_avg_valid, .temp_avg,
        .prog_crc_start, .prog_byte_valid, .prog_byte, .prog_byte_last, .prog_crc_stored, .nv_write_done,
        .nv_readback_ok, .nv_boot_check, .nv_crc_calc, .nv_crc_expected, .nv_main_crc_ok, .nv_mirror_crc_ok,
        .nv_copies_differ, .boot_done, .db_load, .db_positive, .db_negative, .can_tx_err_count,
        .can_err_passive, .can_bus_off, .pdo_rx_valid, .pdo_rx_len, .pdo_expected_len, .pdo_accept,
        .nv_repair_valid, .nv_repair_from_mirror, .fault_active, .error_register, .operation_blocked,
        .emcy_valid, .emcy_ready, .emcy_code, .emcy_err_reg, .emcy_od_index);
    fcr_master_model u_master (.clk, .reset, .emcy_valid, .slow, .emcy_ready);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    function automatic logic [7:0] exp_reg();
        exp_reg = 8'h00;
        for (int i = 0; i < 19; i++) if (exp_mask[i]) exp_reg |= fcr_pkg::ERR_REG[i];
    endfunction
    function automatic logic [15:0] crc_byte(input logic [7:0] d);
        crc_byte = fcr_pkg::CRC_INIT;
        for (int i = 7; i >= 0; i--) crc_byte = {crc_byte[14:0], 1'b0} ^ ((crc_byte[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    endfunction
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask
    task automatic note(input int i);
        exp_mask[i] = 1'b1;
        code_q.push_back(i);
    endtask
    task automatic verify();
        check(fault_active, exp_mask);
        check(error_register, exp_reg());
    endtask
    task automatic drain(string name);
        for (int i = 0; i < 40 && code_q.size() > 0; i++) @(negedge clk);
        check(code_q.size(), 0);
        $display("test %s done", name);
    endtask
    task automatic crc_run(input logic [15:0] stored);
        prog_crc_stored = stored;
        pulse(prog_crc_start);
        prog_byte_last = 1'b1;
        pulse(prog_byte_valid);
        prog_byte_last = 1'b0;
        @(negedge clk);
        @(negedge clk);
    endtask

    // each record checked against the oldest note
    always @(posedge clk) begin
        if (!reset && emcy_valid === 1'b1 && emcy_ready === 1'b1) begin
            b = code_q.size() ? code_q.pop_front() : 99;
            check(emcy_code, fcr_pkg::ERR_CODE[b]);
            check(emcy_err_reg, fcr_pkg::ERR_REG[b]);
            check(emcy_od_index, 16'(16'h2008 + b));
        end
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            end_of_test();
        end
    end

    initial begin
        seed = 32'h5aec717d;
        {app_reset, comm_reset, sup_handshake_miss, sup_post_bad, os_fail, ram_test_fail, pos_test_invalid} = '0;
        {nb_pos_valid, temp_sensor_bad, temp_avg_valid, prog_crc_start, prog_byte_valid, prog_byte_last} = '0;
        {nv_write_done, nv_readback_ok, nv_boot_check, nv_main_crc_ok, nv_mirror_crc_ok, nv_copies_differ} = '0;
        {boot_done, db_load, can_err_passive, can_bus_off, pdo_rx_valid, slow, nb_pos_value, prog_byte} = '0;
        {can_tx_err_count, prog_crc_stored, nv_crc_calc, nv_crc_expected, temp_avg, db_positive, db_negative} = '0;
        {pdo_rx_len, exp_mask, err_total, checks_done, cycles} = '0;
        pdo_expected_len = 4'h8;
        reset = 1'b1;
        repeat (10) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        nv_crc_calc = 16'h1234;
        nv_crc_expected = 16'h1235;
        {nv_mirror_crc_ok, nv_copies_differ} = 2'b11;
        pulse(nv_boot_check); note(11); note(12); verify();
        check(nv_repair_from_mirror, 1'b1); check(nv_repair_valid, 1'b1);
        pulse(boot_done); drain("boot");
        slow = 1'b1;
        pulse(sup_handshake_miss); note(0); verify(); drain("handshake");
        pulse(sup_post_bad); note(1); verify(); drain("startup");
        pulse(os_fail); note(2); verify(); drain("os");
        pulse(ram_test_fail); note(6); verify(); drain("ram");
        pulse(temp_sensor_bad); note(5); verify(); drain("tsens");
        slow = 1'b0;
        nb_pos_value = 12'h100 | (12'($random(seed)) & 12'h7ff);
        pulse(nb_pos_valid); verify();
        nb_pos_value = 12'h0cb;
        pulse(nb_pos_valid); note(4); verify(); drain("neighbour");
        temp_avg = 16'sd85;
        pulse(temp_avg_valid); verify();
        temp_avg = 16'sd86;
        pulse(temp_avg_valid); note(7); verify(); drain("tavg");
        {db_positive, db_negative} = {16'sd1000, -16'sd1000};
        pulse(db_load); verify(); check(operation_blocked, 1'b0);
        db_negative = -16'sd1001;
        pulse(db_load); note(13); verify(); check(operation_blocked, 1'b1);
        drain("deadband");
        nv_readback_ok = 1'b1;
        pulse(nv_write_done); verify();
        nv_readback_ok = 1'b0;
        pulse(nv_write_done); note(10); verify(); drain("nvwrite");
        prog_byte = 8'($random(seed));
        crc_r = crc_byte(prog_byte);
        crc_run(crc_r); verify();
        note(8); crc_run(crc_r ^ 16'h0001); verify(); drain("crc");
        pos_test_invalid = 1'b1;
        repeat (15) @(negedge clk);
        pos_test_invalid = 1'b0;
        @(negedge clk); verify();
        note(3); pos_test_invalid = 1'b1;
        repeat (30) @(negedge clk);
        pos_test_invalid = 1'b0;
        verify(); drain("filter");
        {can_err_passive, can_tx_err_count} = {1'b1, 8'h7f};
        repeat (3) @(negedge clk); verify();
        note(15); can_tx_err_count = 8'h80;
        repeat (3) @(negedge clk); verify();
        note(17); {can_err_passive, can_tx_err_count} = '0;
        repeat (3) @(negedge clk); verify(); drain("can");
        pdo_rx_len = 4'h8;
        pulse(pdo_rx_valid); check(pdo_accept, 1'b1);
        pdo_rx_len = 4'h7;
        pulse(pdo_rx_valid); note(18); verify(); check(pdo_accept, 1'b0);
        drain("pdo");
        pulse(comm_reset); exp_mask &= ~fcr_pkg::COMM_CLR_MASK; verify();
        pulse(app_reset); exp_mask &= ~fcr_pkg::APP_CLR_MASK; verify();
        pulse(temp_avg_valid); note(7); verify(); drain("clear");
        end_of_test();
    end
endmodule // fault_code_reporter_tb_top

// file: verification/fcr_master_model.sv
// Purpose: master side that takes emergency records
// Assumes: drives on the falling edge
// Notes:   slow mode stalls each record a few cycles
`timescale 1ns/100ps
module fcr_master_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // emergency handshake
    input  wire logic emcy_valid,
    input  wire logic slow,
    output logic      emcy_ready
);
    logic [1:0] wait_q;
    // ready stands one edge, so one record per handshake
    always @(negedge clk or posedge reset) begin
        if (reset) begin
            emcy_ready <= 1'b0;
            wait_q     <= 2'h0;
        end else if (emcy_valid && !emcy_ready) begin
            wait_q     <= wait_q + 2'h1;
            emcy_ready <= !slow || wait_q == 2'h3;
        end else begin
            emcy_ready <= 1'b0;
            wait_q     <= 2'h0;
        end
    end
endmodule // fcr_master_model

// file: verification/fcr_reporter_chk.sv
// Purpose: concurrent checks on the fault reporter ports
// Assumes: one clock domain, reset is the power cycle
// Notes:   watches only the top module ports
`timescale 1ns/100ps
module fcr_reporter_chk (
    // clock and reset
    input wire logic               clk,
    input wire logic               reset,
    // watched inputs
    input wire logic               sup_handshake_miss,
    input wire logic               pdo_rx_valid,
    input wire logic        [3:0]  pdo_rx_len,
    input wire logic        [3:0]  pdo_expected_len,
    input wire logic               db_load,
    input wire logic signed [15:0] db_negative,
    input wire logic        [7:0]  can_tx_err_count,
    input wire logic               can_err_passive,
    input wire logic               emcy_ready,
    // watched outputs
    input wire logic               pdo_accept,
    input wire logic        [18:0] fault_active,
    input wire logic        [7:0]  error_register,
    input wire logic               operation_blocked,
    input wire logic               emcy_valid,
    input wire logic        [15:0] emcy_code,
    input wire logic        [15:0] emcy_od_index
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    chk_hs_raise: assert property (sup_handshake_miss |=> fault_active[0] && error_register[7] && error_register[0])
        else $error("handshake fault not raised");
    chk_power_latch: assert property (!$fell(fault_active[0]) && !$fell(fault_active[8]) && !$fell(fault_active[18]))
        else $error("power class fault cleared without power cycle");
    chk_reserved_quiet: assert property (!fault_active[9] && !fault_active[14] && !fault_active[16])
        else $error("reserved fault raised");
    chk_pdo_good: assert property (pdo_rx_valid && pdo_rx_len == pdo_expected_len |=> pdo_accept)
        else $error("good pdo not accepted");
    chk_pdo_bad: assert property (pdo_rx_valid && pdo_rx_len != pdo_expected_len |=> !pdo_accept && fault_active[18])
        else $error("bad pdo not refused");
    chk_db_block: assert property (db_load && db_negative < -16'sh03e8 |=> operation_blocked && fault_active[13])
        else $error("dead band not blocking");
    chk_can_warn: assert property ($rose(can_err_passive && can_tx_err_count > 8'h7f) |-> ##[1:2] fault_active[15])
        else $error("error passive warning missing");
    chk_emcy_hold: assert property (emcy_valid && !emcy_ready |=> emcy_valid && $stable(emcy_code) && $stable(emcy_od_index))
        else $error("emergency record changed while waiting");
    chk_emcy_pair: assert property (emcy_valid |-> emcy_code == fcr_pkg::ERR_CODE[emcy_od_index[4:0] - 5'h08])
        else $error("code and dictionary index disagree");
    chk_emcy_done: assert property (emcy_valid && emcy_ready |=> !emcy_valid)
        else $error("record not retired after handshake");
endmodule // fcr_reporter_chk

bind fcr_reporter fcr_reporter_chk u_chk (
    .clk(clk), .reset(reset), .sup_handshake_miss(sup_handshake_miss), .pdo_rx_valid(pdo_rx_valid),
    .pdo_rx_len(pdo_rx_len), .pdo_expected_len(pdo_expected_len), .db_load(db_load), .db_negative(db_negative),
    .can_tx_err_count(can_tx_err_count), .can_err_passive(can_err_passive), .emcy_ready(emcy_ready),
    .pdo_accept(pdo_accept), .fault_active(fault_active), .error_register(error_register),
    .operation_blocked(operation_blocked), .emcy_valid(emcy_valid), .emcy_code(emcy_code),
    .emcy_od_index(emcy_od_index));
